// [verilog/tbio_top.sv]
//Contract
// RL1: 24 lines, direction set per 8-line group
// RL2: direction 0 input, 1 output
// RL3: all ports input after reset
// RL4: output latch written even while input
// RL5: port select 0 to 2 for every access
// RL6: whole-port write loads 8-bit latch value
// RL7: individual bits set or cleared by mask
// RL8: bit write leaves other bits unchanged
// RL9: read returns current levels of eight lines
// RL10: trap index 0-15 gp, 16-39 bus
// RL11: polarity 0 fires low, 1 high
// RL12: level 0 off, 1-4 armed redirect
// RL13: levels 1,4 abort motion; 2,3 not
// RL14: levels 3,4 disarm after firing once
// RL15: polarity 0 level 1 fires on falling
// RL16: one-cycle fire with abort and target
`timescale 1ns/100ps
`default_nettype none
module tbio_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] port_sel_i,
    input wire logic port_direction_setup_we_i,
    input wire logic port_direction_setup_i,
    input wire logic byte_we_i,
    input wire logic [tbio_pkg::PORT_W-1:0] byte_val_i,
    input wire logic bit_we_i,
    input wire logic [tbio_pkg::PORT_W-1:0] bit_mask_i,
    input wire logic [tbio_pkg::PORT_W-1:0] bit_val_i,
    input wire logic rd_req_i,
    output logic [tbio_pkg::PORT_W-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [tbio_pkg::BUS_W-1:0] io_pad_i,
    output logic [tbio_pkg::BUS_W-1:0] io_pad_o,
    output logic [tbio_pkg::BUS_W-1:0] io_oe_b_o,
    output logic [tbio_pkg::NUM_PORTS-1:0] port_dir_o,
    input wire logic [tbio_pkg::GP_W-1:0] gp_in_i,
    input wire logic trap_cfg_we_i,
    input wire logic [2:0] trap_action_level_i,
    input wire logic [tbio_pkg::SEL_W-1:0] trap_line_select_i,
    input wire logic trap_polarity_i,
    input wire logic [tbio_pkg::TGT_W-1:0] trap_target_i,
    output logic trap_fire_o,
    output logic trap_abort_o,
    output logic [tbio_pkg::TGT_W-1:0] trap_target_o,
    output logic trap_armed_o
);
    import tbio_pkg::*;

    typedef struct packed {
        logic [BUS_W-1:0] io_s1;
        logic [BUS_W-1:0] io_s2;
        logic [GP_W-1:0] gp_s1;
        logic [GP_W-1:0] gp_s2;
        logic [NUM_PORTS-1:0] dir;
        logic [BUS_W-1:0] latch;
        logic [PORT_W-1:0] rd_data;
        logic rd_valid;
        logic [BUS_W-1:0] pad_o;
        logic [BUS_W-1:0] oe_b;
    } tbio_top_s;

    tbio_top_s top_reg;
    tbio_top_s top_next;
    logic sel_ok;
    logic [4:0] base;

    // trap sees only synchronised levels, never raw pins
    tbio_trap_if trap_bus ();

    // ****************************************
    // port access
    // ****************************************
    always_comb begin
        // port 3 is refused: no answer, no state change
        sel_ok = (port_sel_i <= PORT_LAST); // [RL5]
        base = {port_sel_i, 3'h0};
        top_next = top_reg;
        // pins are asynchronous to clk_i; two stages before any use
        top_next.io_s1 = io_pad_i;
        top_next.io_s2 = top_reg.io_s1;
        top_next.gp_s1 = gp_in_i;
        top_next.gp_s2 = top_reg.gp_s1;
        if (port_direction_setup_we_i && sel_ok) begin
            top_next.dir[port_sel_i] = port_direction_setup_i; // [RL2]
        end
        // latch is written regardless of direction so it is ready when the port turns output
        if (byte_we_i && sel_ok) begin
            top_next.latch[base +: PORT_W] = byte_val_i; // [RL4] [RL6]
        end
        if (bit_we_i && sel_ok) begin
            for (int i = 0; i < PORT_W; i++) begin
                if (bit_mask_i[i]) begin
                    top_next.latch[base + 5'(i)] = bit_val_i[i]; // [RL7] [RL8]
                end
            end
        end
        // read data holds between reads so a slow sampler still sees it
        top_next.rd_valid = rd_req_i && sel_ok;
        top_next.rd_data = (rd_req_i && sel_ok) ? top_reg.io_s2[base +: PORT_W] : top_reg.rd_data; // [RL9]
        // latch drives io_pad_o always; only the enable decides the pin
        top_next.pad_o = top_next.latch;
        for (int p = 0; p < NUM_PORTS; p++) begin
            top_next.oe_b[p*PORT_W +: PORT_W] = {PORT_W{~top_next.dir[p]}}; // [RL1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            top_reg <= '0;
            top_reg.dir <= DIR_RST; // [RL3]
            top_reg.latch <= LATCH_RST;
            top_reg.pad_o <= LATCH_RST;
            top_reg.oe_b <= OE_B_RST;
        end else begin
            top_reg <= top_next;
        end
    end

    // ****************************************
    // input trap
    // ****************************************
    assign trap_bus.gp_lvl = top_reg.gp_s2;
    assign trap_bus.io_lvl = top_reg.io_s2;
    assign trap_bus.cfg_we = trap_cfg_we_i;
    assign trap_bus.level = trap_action_level_i;
    assign trap_bus.line = trap_line_select_i;
    assign trap_bus.pol = trap_polarity_i;
    assign trap_bus.target = trap_target_i;

    tbio_trap u_trap (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .t(trap_bus.trap)
    );

    assign rd_data_o = top_reg.rd_data;
    assign rd_valid_o = top_reg.rd_valid;
    assign io_pad_o = top_reg.pad_o;
    assign io_oe_b_o = top_reg.oe_b;
    assign port_dir_o = top_reg.dir;
    assign trap_fire_o = trap_bus.fire;
    assign trap_abort_o = trap_bus.abort;
    assign trap_target_o = trap_bus.fire_target;
    assign trap_armed_o = trap_bus.armed;

    // ****************************************
    // checks
    // ****************************************
    reset_all_input_a: assert property (@(posedge clk_i) // [RL3]
        !rst_b_i |=> io_oe_b_o == OE_B_RST && port_dir_o == DIR_RST)
        else $error("port not input after reset");
    reset_trap_off_a: assert property (@(posedge clk_i) // [RL12]
        !rst_b_i |=> !trap_fire_o && !trap_abort_o && !trap_armed_o && !rd_valid_o)
        else $error("trap or read answer active after reset");
    dir_to_oe_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL1] [RL2]
        port_direction_setup_we_i && sel_ok |=>
        io_oe_b_o[$past(base) +: PORT_W] == {PORT_W{~$past(port_direction_setup_i)}})
        else $error("direction not applied to group");
    byte_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL6] [RL4]
        byte_we_i && !bit_we_i && sel_ok |=> io_pad_o[$past(base) +: PORT_W] == $past(byte_val_i))
        else $error("byte write not latched");
    byte_then_bits_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL6] [RL7]
        byte_we_i && bit_we_i && sel_ok |=> io_pad_o[$past(base) +: PORT_W] ==
        (($past(byte_val_i) & ~$past(bit_mask_i)) | ($past(bit_val_i) & $past(bit_mask_i))))
        else $error("masked bits not applied over byte");
    bit_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL7] [RL8]
        bit_we_i && !byte_we_i && sel_ok |=>
        ((io_pad_o[$past(base) +: PORT_W] ^ $past(top_reg.latch[base +: PORT_W])) & ~$past(bit_mask_i)) == 8'h00 &&
        ((io_pad_o[$past(base) +: PORT_W] ^ $past(bit_val_i)) & $past(bit_mask_i)) == 8'h00)
        else $error("bit write disturbed latch");
    read_answer_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL9] [RL5]
        rd_req_i |=> rd_valid_o == $past(sel_ok) &&
        (!rd_valid_o || rd_data_o == $past(top_reg.io_s2[base +: PORT_W])))
        else $error("read answer wrong");
    read_holds_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL9]
        !(rd_req_i && sel_ok) |=> $stable(rd_data_o))
        else $error("read data moved without a read");
    read_sync_depth_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL9]
        rd_req_i && sel_ok && $past(rst_b_i) && $past(rst_b_i, 2) |=>
        rd_data_o == 8'($past(io_pad_i, 3) >> $past(base)))
        else $error("read data not from synced pins");
    bad_port_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL5]
        !sel_ok && !trap_cfg_we_i |=> $stable(io_pad_o) && $stable(port_dir_o))
        else $error("port 3 access changed state");

    // ****************************************
    // trap checks
    // ****************************************
    abort_with_fire_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL13] [RL16]
        trap_abort_o |-> trap_fire_o) else $error("abort without fire");
    target_on_fire_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL16]
        $changed(trap_target_o) |-> trap_fire_o) else $error("target changed without fire");
    armed_by_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL12]
        trap_cfg_we_i |=>
        trap_armed_o == ($past(trap_action_level_i) != LVL_OFF && $past(trap_action_level_i) <= LVL_ABORT_ONCE))
        else $error("armed state does not follow level");
    fire_when_armed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL12]
        trap_fire_o |-> $past(trap_armed_o)) else $error("trap fired while off");

    // ****************************************
    // per-port checks
    // ****************************************
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_chk
        oe_group_whole_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL1]
            io_oe_b_o[p*PORT_W +: PORT_W] == {PORT_W{~port_dir_o[p]}})
            else $error("output enable group split");
        dir_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL2] [RL5]
            port_direction_setup_we_i && port_sel_i == 2'(p) |=> port_dir_o[p] == $past(port_direction_setup_i))
            else $error("direction write missed its port");
        dir_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL5] [RL2]
            !(port_direction_setup_we_i && port_sel_i == 2'(p)) |=> $stable(port_dir_o[p]))
            else $error("direction of untouched port changed");
        latch_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL5] [RL8]
            !((byte_we_i || bit_we_i) && port_sel_i == 2'(p)) |=>
            $stable(io_pad_o[p*PORT_W +: PORT_W]))
            else $error("latch of untouched port changed");
    end
endmodule : tbio_top
`default_nettype wire

// [verilog/tbio_pkg.sv]
`default_nettype none
package tbio_pkg;
    // ****************************************
    // bus geometry
    // ****************************************
    localparam int NUM_PORTS = 3;
    localparam int PORT_W = 8;
    localparam int BUS_W = 24;
    localparam int GP_W = 16;
    localparam int SEL_W = 6;
    localparam int TGT_W = 8;
    localparam logic [1:0] PORT_LAST = 2'h2;
    localparam logic [2:0] PORT_SHIFT = 3'h3;

    // ****************************************
    // trap line index ranges
    // ****************************************
    localparam logic [SEL_W-1:0] GP_LAST = 6'h0F;
    localparam logic [SEL_W-1:0] IO_FIRST = 6'h10;
    localparam logic [SEL_W-1:0] IO_LAST = 6'h27;

    // ****************************************
    // trap action level codes
    // ****************************************
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam logic [2:0] LVL_ABORT_KEEP = 3'h1;
    localparam logic [2:0] LVL_FLOW_KEEP = 3'h2;
    localparam logic [2:0] LVL_FLOW_ONCE = 3'h3;
    localparam logic [2:0] LVL_ABORT_ONCE = 3'h4;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [NUM_PORTS-1:0] DIR_RST = 3'h0;
    localparam logic [BUS_W-1:0] LATCH_RST = 24'h000000;
    localparam logic [BUS_W-1:0] OE_B_RST = 24'hFFFFFF;
    localparam logic [TGT_W-1:0] TGT_RST = 8'h00;
endpackage : tbio_pkg
`default_nettype wire

// [verilog/tbio_trap_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface tbio_trap_if;
    import tbio_pkg::*;
    logic [GP_W-1:0] gp_lvl;
    logic [BUS_W-1:0] io_lvl;
    logic cfg_we;
    logic [2:0] level;
    logic [SEL_W-1:0] line;
    logic pol;
    logic [TGT_W-1:0] target;
    logic fire;
    logic abort;
    logic [TGT_W-1:0] fire_target;
    logic armed;
    modport top (output gp_lvl, io_lvl, cfg_we, level, line, pol, target,
                 input fire, abort, fire_target, armed);
    modport trap (input gp_lvl, io_lvl, cfg_we, level, line, pol, target,
                  output fire, abort, fire_target, armed);
endinterface : tbio_trap_if
`default_nettype wire

// [verilog/tbio_trap.sv]
`timescale 1ns/100ps
`default_nettype none
module tbio_trap (
    input wire logic clk_i,
    input wire logic rst_b_i,
    tbio_trap_if.trap t
);
    import tbio_pkg::*;

    typedef struct packed {
        logic [2:0] level;
        logic [SEL_W-1:0] line;
        logic pol;
        logic [TGT_W-1:0] target;
        logic prev_act;
        logic fire;
        logic abort;
        logic [TGT_W-1:0] fire_target;
        logic armed;
    } tbio_trap_s;

    tbio_trap_s trap_reg;
    tbio_trap_s trap_next;
    logic line_lvl;
    logic line_act;
    logic fire_now;

    // ****************************************
    // watched line and firing
    // ****************************************
    always_comb begin
        if (trap_reg.line <= GP_LAST) begin // [RL10]
            line_lvl = t.gp_lvl[trap_reg.line[3:0]];
        end else if (trap_reg.line <= IO_LAST) begin
            line_lvl = t.io_lvl[5'(trap_reg.line - IO_FIRST)];
        end else begin
            line_lvl = ~trap_reg.pol;
        end
        line_act = trap_reg.pol ? line_lvl : ~line_lvl; // [RL11]
        // entry into the active level only, so a held level fires once per occurrence
        fire_now = (trap_reg.level != LVL_OFF) && line_act && !trap_reg.prev_act; // [RL12] [RL15]
        trap_next = trap_reg;
        trap_next.prev_act = line_act;
        trap_next.fire = fire_now; // [RL16]
        trap_next.abort = fire_now && (trap_reg.level == LVL_ABORT_KEEP ||
                                       trap_reg.level == LVL_ABORT_ONCE); // [RL13]
        if (fire_now) begin
            trap_next.fire_target = trap_reg.target;
        end
        if (fire_now && (trap_reg.level == LVL_FLOW_ONCE || trap_reg.level == LVL_ABORT_ONCE)) begin
            trap_next.level = LVL_OFF; // [RL14]
        end
        if (t.cfg_we) begin
            // unknown codes disable rather than guess an action
            trap_next.level = (t.level > LVL_ABORT_ONCE) ? LVL_OFF : t.level; // [RL12]
            trap_next.line = t.line;
            trap_next.pol = t.pol;
            trap_next.target = t.target;
            trap_next.prev_act = 1'b0;
        end
        trap_next.armed = (trap_next.level != LVL_OFF);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            trap_reg <= '0;
            trap_reg.fire_target <= TGT_RST;
        end else begin
            trap_reg <= trap_next;
        end
    end

    assign t.fire = trap_reg.fire;
    assign t.abort = trap_reg.abort;
    assign t.fire_target = trap_reg.fire_target;
    assign t.armed = trap_reg.armed;

    // ****************************************
    // checks
    // ****************************************
    fire_single_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL16]
        trap_reg.fire |=> !trap_reg.fire) else $error("trap fire longer than one cycle");
    fire_needs_active_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL11]
        trap_reg.fire |-> $past(line_act) && !$past(trap_reg.prev_act))
        else $error("fire without active edge");
    once_disarms_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL14]
        fire_now && trap_reg.level >= LVL_FLOW_ONCE && !t.cfg_we |=> !trap_reg.armed)
        else $error("one-shot trap still armed");
    keep_stays_armed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL14]
        fire_now && trap_reg.level <= LVL_FLOW_KEEP && !t.cfg_we |=> trap_reg.armed)
        else $error("repeating trap disarmed");
    abort_by_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RL13]
        fire_now |=> trap_reg.abort == ($past(trap_reg.level) == LVL_ABORT_KEEP ||
                                        $past(trap_reg.level) == LVL_ABORT_ONCE))
        else $error("abort flag wrong for level");
endmodule : tbio_trap
`default_nettype wire

// [tb/tbio_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tbio_pins_model (
    input wire logic clk_i,
    input wire logic [tbio_pkg::BUS_W-1:0] pad_o_i,
    input wire logic [tbio_pkg::BUS_W-1:0] oe_b_i,
    input wire logic [tbio_pkg::BUS_W-1:0] ext_val_i,
    input wire logic [tbio_pkg::BUS_W-1:0] ext_en_i,
    output logic [tbio_pkg::BUS_W-1:0] pad_i_o
);
    import tbio_pkg::*;
    // ********
    // field wiring
    // ********
    logic [BUS_W-1:0] float_pat = 24'h5A5A5A;
    // undriven lines wander so no stale level can pass for a real one
    always @(posedge clk_i) float_pat <= ~float_pat;
    // device drives its output groups, field drives the rest
    assign pad_i_o = (~oe_b_i & pad_o_i) | (oe_b_i & ext_en_i & ext_val_i) | (oe_b_i & ~ext_en_i & float_pat);
endmodule : tbio_pins_model
`default_nettype wire

// [tb/tbio_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tbio_tb_top;
    import tbio_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic dir_we = 1'b0, dir_v = 1'b0, byte_we = 1'b0, bit_we = 1'b0, rd_req = 1'b0, cfg_we = 1'b0, pol = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] bval = 8'h00, mask = 8'h00, mval = 8'h00, tgt = 8'h00, rd_data, tgt_o;
    logic [2:0] lvl = 3'h0;
    logic [2:0] pdir;
    logic [5:0] line = 6'h00;
    logic [15:0] gp = 16'h0000;
    logic [23:0] ext = 24'h000000, ext_en = 24'hFFFFFF, pad_i, pad_o, oe_b;
    logic rd_valid, fire, abort, armed;
    int err_total = 0, compares = 0;
    int m_latch[3] = '{0, 0, 0}, m_dir[3] = '{0, 0, 0};
    always #2.5 clk_i = ~clk_i;
    tbio_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .port_sel_i(sel), .port_direction_setup_we_i(dir_we),
        .port_direction_setup_i(dir_v), .byte_we_i(byte_we), .byte_val_i(bval), .bit_we_i(bit_we), .bit_mask_i(mask),
        .bit_val_i(mval), .rd_req_i(rd_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .io_pad_i(pad_i),
        .io_pad_o(pad_o), .io_oe_b_o(oe_b), .port_dir_o(pdir), .gp_in_i(gp), .trap_cfg_we_i(cfg_we),
        .trap_action_level_i(lvl), .trap_line_select_i(line), .trap_polarity_i(pol), .trap_target_i(tgt),
        .trap_fire_o(fire), .trap_abort_o(abort), .trap_target_o(tgt_o), .trap_armed_o(armed));
    tbio_pins_model u_pins (.clk_i(clk_i), .pad_o_i(pad_o), .oe_b_i(oe_b), .ext_val_i(ext), .ext_en_i(ext_en),
        .pad_i_o(pad_i));
    // ********
    // helpers
    // ********
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic check_ports;
        for (int p = 0; p < 3; p++) begin
            chk("latch", 32'(pad_o[8*p+:8]), m_latch[p]);
            chk("oe_b", 32'(oe_b[8*p+:8]), m_dir[p] ? 0 : 255);
            chk("dir", 32'(pdir[p]), m_dir[p]);
        end
    endtask : check_ports
    // kind 0 direction, 1 byte, 2 masked bits, 3 read, 4 byte then bits
    task automatic drive(input int kind, input int s, input logic [7:0] a, input logic [7:0] b);
        logic [7:0] exp_rd;
        exp_rd = m_dir[s%3] ? 8'(m_latch[s%3]) : ext[8*(s%3)+:8];
        @(posedge clk_i);
        sel <= 2'(s);
        dir_we <= (kind == 0);
        dir_v <= a[0];
        byte_we <= (kind == 1 || kind == 4);
        bval <= a;
        bit_we <= (kind == 2 || kind == 4);
        mask <= (kind == 4) ? b : a;
        mval <= b;
        rd_req <= (kind == 3);
        @(posedge clk_i);
        {dir_we, byte_we, bit_we, rd_req} <= 4'h0;
        #1;
        if (s < 3 && kind == 0) m_dir[s] = a[0];
        if (s < 3 && kind == 1) m_latch[s] = a;
        if (s < 3 && kind == 2) m_latch[s] = (m_latch[s] & ~a) | (a & b);
        if (s < 3 && kind == 4) m_latch[s] = (a & ~b) | b;
        chk("rd_valid", 32'(rd_valid), kind == 3 && s < 3);
        if (kind == 3 && s < 3) chk("rd_data", 32'(rd_data), exp_rd);
        check_ports;
    endtask : drive
    task automatic set_line(input int idx, input logic v);
        @(posedge clk_i);
        if (idx < 16) gp[idx] <= v;
        else ext[idx-16] <= v;
    endtask : set_line
    task automatic count_fire(input int n_exp, input logic ab, input logic [7:0] t);
        int n;
        n = 0;
        repeat (8) begin
            @(posedge clk_i);
            #1;
            if (fire === 1'b1) begin
                n++;
                chk("target", 32'(tgt_o), t);
            end
            chk("abort", 32'(abort), fire === 1'b1 && ab);
        end
        chk("fires", n, n_exp);
    endtask : count_fire
    task automatic trap_run(input int l, input int idx, input logic p);
        logic [7:0] t;
        t = 8'($urandom);
        set_line(idx, ~p);
        repeat (4) @(posedge clk_i);
        cfg_we <= 1'b1;
        lvl <= 3'(l);
        line <= 6'(idx);
        pol <= p;
        tgt <= t;
        @(posedge clk_i);
        cfg_we <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("armed", 32'(armed), l != 0);
        set_line(idx, p);
        count_fire(l != 0, l == 1 || l == 4, t);
        chk("rearmed", 32'(armed), l == 1 || l == 2);
        set_line(idx, ~p);
        repeat (4) @(posedge clk_i);
        set_line(idx, p);
        count_fire(l == 1 || l == 2, l == 1 || l == 4, t);
        set_line(idx, ~p);
    endtask : trap_run
    // ********
    // sequence
    // ********
    initial begin
        void'($urandom(32'hC6456606));
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        check_ports;
        for (int p = 0; p < 3; p++) drive(1, p, 8'($urandom), 8'h00);
        for (int p = 0; p < 3; p++) drive(0, p, 8'h01, 8'h00);
        for (int i = 0; i < 16; i++) drive(2, $urandom % 3, 8'($urandom), 8'($urandom));
        for (int i = 0; i < 3; i++) drive(4, i, 8'($urandom), 8'($urandom));
        for (int k = 0; k < 5; k++) drive(k, 3, 8'hFF, 8'hFF);
        drive(0, 1, 8'h00, 8'h00);
        drive(0, 2, 8'h00, 8'h00);
        @(posedge clk_i);
        ext <= 24'($urandom);
        repeat (3) @(posedge clk_i);
        for (int p = 0; p < 4; p++) drive(3, p, 8'h00, 8'h00);
        for (int l = 0; l < 5; l++) begin
            trap_run(l, 3 * l, l[0]);
            trap_run(l, 32 + l, ~l[0]);
        end
        trap_run(1, 0, 1'b0);
        close_out();
    end
    // whole run needs under 500 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule : tbio_tb_top
`default_nettype wire
